//--- core/vpl_clock_divider.sv
// pixel/load clock divider core: reference and word-width dividers,
// load strobes, enable chain, phase detectors, processor clock phases
// assumes all inputs synchronous to pclk; pclk stands for the pixel clock
//
// What this block does
// - reference divider divides by any integer one through eight
// - word-width modulus programmable 4 to 64 pixel clocks, steps of 4
// - three select inputs give division ratio equal to binary value plus one
// - one shifter load pulse every word-width modulus pixel clocks
// - all four load strobes derived from the word-width divider output
// - shifter load strobe differential and aligned to pixel clock edges
// - fifo mode: shifter load two load periods after fifo write
// - order: memory shift, then fifo writes, then shifter load
// - aux comparator steers external oscillator from horizontal phase error
// - reference divider precedes the phase detector in the loop
// - locked: pixel rate is reference times word modulus over ref modulus
// - processor clock phases run at the 1x reference rate
// - 1x reference resampled by the 2x reference clock
// - all load and pixel outputs generated synchronously together
//
// Added by the designer: the APB register port and the register offsets.
module vpl_clock_divider
   import vpl_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ref_div_sel_bit0,
   input wire logic ref_div_sel_bit1,
   input wire logic ref_div_sel_bit2,
   input wire logic reference_1x_input,
   input wire logic reference_2x_clock,
   input wire logic horizontal_feedback_input,
   input wire logic ext_horizontal_ref,
   input wire logic load_timing_adjust,
   input wire logic chain_enable_in_first,
   input wire logic chain_enable_in_third,
   output logic chain_enable_out_first,
   output logic chain_enable_out_second,
   output logic chain_enable_out_third,
   output logic chain_enable_out_third_n,
   output logic word_strobe_ttl_a,
   output logic memory_shift_strobe,
   output logic fifo_write_strobe,
   output logic shifter_load_strobe,
   output logic shifter_load_strobe_n,
   output logic ref_divider_output,
   output logic processor_phase_one,
   output logic processor_phase_two,
   output logic pump_up,
   output logic pump_down,
   output logic aux_pump_up,
   output logic aux_pump_down
);

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic rise(input logic cur, input logic prev);
      rise = cur & ~prev;
   endfunction : rise

   // charge-pump style detector: {up, dn} next state
   function automatic logic [1:0] pd_next(input logic up, input logic dn,
                                          input logic a, input logic b);
      logic [1:0] r;
      r = {up, dn};
      if (a && !b)
      begin
         r = dn ? 2'h0 : 2'h2;
      end
      else if (b && !a)
      begin
         r = up ? 2'h0 : 2'h1;
      end
      else if (a && b)
      begin
         r = 2'h0;
      end
      pd_next = r;
   endfunction : pd_next

   // ---------------------------------------------------------------
   // apb registers
   // ---------------------------------------------------------------
   logic [3:0] wsel_r;
   logic run_r;
   logic lock_r;
   logic aux_lock_r;
   logic [2:0] sel;
   logic [3:0] s_mod;
   logic [6:0] l_mod;
   logic [VPL_STAGES-1:0] en_in_r;
   logic [VPL_STAGES-1:0] en_out_r;
   logic wr_en;

   assign sel = {ref_div_sel_bit2, ref_div_sel_bit1, ref_div_sel_bit0};
   assign s_mod = {1'b0, sel} + VPL_S_ONE;
   assign l_mod = 7'({wsel_r, 2'b00}) + VPL_L_STEP;
   assign wr_en = psel && penable && pwrite;
   assign pready = 1'b1;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wsel_r <= VPL_WSEL_RST;
         run_r <= VPL_RUN_RST;
      end
      else if (wr_en && paddr == VPL_OFS_CTRL)
      begin
         wsel_r <= pwdata[VPL_CTRL_WSEL_LSB +: 4];
         run_r <= pwdata[VPL_CTRL_RUN_BIT];
      end
   end

   always_comb
   begin
      prdata = 32'h0000_0000;
      pslverr = 1'b0;
      case (paddr)
         VPL_OFS_CTRL:
         begin
            prdata[VPL_CTRL_WSEL_LSB +: 4] = wsel_r;
            prdata[VPL_CTRL_RUN_BIT] = run_r;
         end
         VPL_OFS_STAT:
         begin
            prdata[VPL_STAT_LOCK_BIT] = lock_r;
            prdata[VPL_STAT_EN_LSB +: VPL_STAGES] = en_in_r;
            prdata[VPL_STAT_AUX_BIT] = aux_lock_r;
            prdata[VPL_STAT_SEL_LSB +: 3] = sel;
         end
         VPL_OFS_MOD:
         begin
            prdata[VPL_MOD_L_LSB +: 7] = l_mod;
            prdata[VPL_MOD_S_LSB +: 4] = s_mod;
         end
         default:
         begin
            pslverr = psel && penable;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // reference resampling and processor phases
   // ---------------------------------------------------------------
   logic ref2x_d;
   logic ref1x_r;
   logic ref1x_d;
   logic r2_rise;
   logic ref_rise;

   assign r2_rise = rise(reference_2x_clock, ref2x_d);
   assign ref_rise = rise(ref1x_r, ref1x_d);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ref2x_d <= 1'b0;
         ref1x_r <= 1'b0;
         ref1x_d <= 1'b0;
      end
      else
      begin
         ref2x_d <= reference_2x_clock;
         if (r2_rise)
         begin
            ref1x_r <= reference_1x_input;
         end
         ref1x_d <= ref1x_r;
      end
   end

   // phases gated against the delayed copy so they never overlap
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         processor_phase_one <= 1'b0;
         processor_phase_two <= 1'b0;
      end
      else
      begin
         processor_phase_one <= ref1x_r & ref1x_d;
         processor_phase_two <= ~ref1x_r & ~ref1x_d;
      end
   end

   // ---------------------------------------------------------------
   // reference divider
   // ---------------------------------------------------------------
   logic [3:0] s_cnt_r;
   logic s_tick;

   assign s_tick = ref_rise && (s_cnt_r >= s_mod - VPL_S_ONE);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_cnt_r <= 4'h0;
         ref_divider_output <= 1'b0;
      end
      else
      begin
         if (ref_rise)
         begin
            s_cnt_r <= s_tick ? 4'h0 : s_cnt_r + 4'h1;
         end
         ref_divider_output <= s_tick;
      end
   end

   // ---------------------------------------------------------------
   // word-width divider
   // ---------------------------------------------------------------
   logic [6:0] l_cnt_r;
   logic [6:0] l_cnt_nxt;
   logic l_last;
   logic l_wrap;

   assign l_last = run_r && (l_cnt_r >= l_mod - 7'h01);
   assign l_cnt_nxt = !run_r ? 7'h00 : (l_last ? 7'h00 : l_cnt_r + 7'h01);
   assign l_wrap = l_last;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         l_cnt_r <= 7'h00;
      end
      else
      begin
         l_cnt_r <= l_cnt_nxt;
      end
   end

   // ---------------------------------------------------------------
   // main and auxiliary phase detectors
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pump_up <= 1'b0;
         pump_down <= 1'b0;
         lock_r <= 1'b0;
      end
      else
      begin
         {pump_up, pump_down} <= pd_next(pump_up, pump_down,
                                         ref_divider_output, l_wrap);
         if (ref_divider_output && l_wrap)
         begin
            lock_r <= 1'b1;
         end
         else if (ref_divider_output || l_wrap)
         begin
            lock_r <= 1'b0;
         end
      end
   end

   logic hfb_d;
   logic href_d;
   logic hfb_rise;
   logic href_rise;

   assign hfb_rise = rise(horizontal_feedback_input, hfb_d);
   assign href_rise = rise(ext_horizontal_ref, href_d);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         hfb_d <= 1'b0;
         href_d <= 1'b0;
         aux_pump_up <= 1'b0;
         aux_pump_down <= 1'b0;
         aux_lock_r <= 1'b0;
      end
      else
      begin
         hfb_d <= horizontal_feedback_input;
         href_d <= ext_horizontal_ref;
         {aux_pump_up, aux_pump_down} <= pd_next(aux_pump_up, aux_pump_down,
                                                 href_rise, hfb_rise);
         if (href_rise && hfb_rise)
         begin
            aux_lock_r <= 1'b1;
         end
         else if (href_rise || hfb_rise)
         begin
            aux_lock_r <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // enable chain: stage 1 first input, stage 2 fed by stage 1,
   // stage 3 from the third input as wired on the board
   // ---------------------------------------------------------------
   logic [VPL_STAGES-1:0] en_src;
   logic [VPL_STAGES-1:0] en_in_nxt;

   assign en_src = {chain_enable_in_third, en_out_r[0],
                    chain_enable_in_first};

   genvar gi;
   generate
      for (gi = 0; gi < VPL_STAGES; gi = gi + 1)
      begin : g_stage
         assign en_in_nxt[gi] = l_last ? en_src[gi] : en_in_r[gi];
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               en_in_r[gi] <= 1'b0;
               en_out_r[gi] <= 1'b0;
            end
            else if (l_last)
            begin
               en_in_r[gi] <= en_src[gi];
               en_out_r[gi] <= en_in_r[gi];
            end
         end
      end
   endgenerate

   assign chain_enable_out_first = en_out_r[0];
   assign chain_enable_out_second = en_out_r[1];
   assign chain_enable_out_third = en_out_r[2];
   assign chain_enable_out_third_n = ~en_out_r[2];

   // ---------------------------------------------------------------
   // load strobes, all registered from the same counter state
   // ---------------------------------------------------------------
   logic word_nxt;
   logic load_nxt;
   logic [6:0] load_pos;

   assign word_nxt = run_r && (l_cnt_nxt < (l_mod >> 1));
   assign load_pos = load_timing_adjust ? 7'h01 : 7'h00;
   assign load_nxt = run_r && (l_cnt_nxt == load_pos) && en_in_nxt[2];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         word_strobe_ttl_a <= 1'b0;
         memory_shift_strobe <= 1'b0;
         fifo_write_strobe <= 1'b0;
         shifter_load_strobe <= 1'b0;
         shifter_load_strobe_n <= 1'b1;
      end
      else
      begin
         word_strobe_ttl_a <= word_nxt;
         memory_shift_strobe <= word_nxt && en_in_nxt[0];
         fifo_write_strobe <= word_nxt && en_in_nxt[1];
         shifter_load_strobe <= load_nxt;
         shifter_load_strobe_n <= ~load_nxt;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic [6:0] ld_gap_r;
   logic ld_seen_r;
   logic ld_adj_r;
   // a period is judged only between two strobes with no setting change
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ld_gap_r <= 7'h00;
         ld_seen_r <= 1'b0;
         ld_adj_r <= 1'b0;
      end
      else
      begin
         ld_gap_r <= shifter_load_strobe ? 7'h01 : ld_gap_r + 7'h01;
         ld_adj_r <= load_timing_adjust;
         if ((wr_en && paddr == VPL_OFS_CTRL) || !en_in_r[2]
             || (load_timing_adjust != ld_adj_r))
         begin
            ld_seen_r <= 1'b0;
         end
         else if (shifter_load_strobe)
         begin
            ld_seen_r <= 1'b1;
         end
         else
         begin
            ld_seen_r <= ld_seen_r && run_r;
         end
      end
   end

   sequence seq_boundary;
      l_last;
   endsequence

   sequence seq_mismatch;
      ref_divider_output && !l_wrap && !pump_down;
   endsequence

   a_sdiv_range: assert property (s_cnt_r < 4'h8)
      else $error("reference count out of range");
   a_sel_ratio: assert property (ref_divider_output |->
      $past(s_cnt_r) == s_mod - VPL_S_ONE || $changed(sel))
      else $error("reference divider ratio wrong");
   // the count may exceed a shrunken modulus for the one cycle after a write
   a_word_range: assert property (l_mod[1:0] == 2'b00 and
      ($stable(wsel_r) |-> l_cnt_r < l_mod))
      else $error("word counter out of range");
   a_load_period: assert property ($rose(shifter_load_strobe) &&
      ld_seen_r && $stable(wsel_r) && $stable(load_timing_adjust) |->
      ld_gap_r == l_mod)
      else $error("load period differs from word modulus");
   a_strobe_derive: assert property (
      (memory_shift_strobe || fifo_write_strobe) |-> word_strobe_ttl_a)
      else $error("strobe not derived from word divider");
   a_load_diff: assert property (
      (shifter_load_strobe_n == !shifter_load_strobe) and
      (shifter_load_strobe && $stable(load_timing_adjust) |=>
      !shifter_load_strobe || l_mod == 7'h04))
      else $error("load strobe pair broken");
   a_chain_delay: assert property (seq_boundary |=>
      en_out_r == $past(en_in_r) && en_in_r == $past(en_src))
      else $error("enable chain stage timing wrong");
   a_pump_set: assert property (seq_mismatch |=> pump_up ##1 1)
      else $error("phase detector did not pump up");
   a_aux_excl: assert property (!(aux_pump_up && aux_pump_down))
      else $error("aux pump up and down together");
   a_phase_sep: assert property (
      !(processor_phase_one && processor_phase_two) and
      ($rose(processor_phase_one) |-> $past(ref1x_r, 2)))
      else $error("processor phases overlap");
   a_resample: assert property ($changed(ref1x_r) |-> $past(r2_rise))
      else $error("1x reference not resampled on 2x edge");

endmodule : vpl_clock_divider

//--- core/vpl_pkg.sv
// constants shared by the pixel/load clock divider core
// assumes a single pclk domain and an apb register port
package vpl_pkg;

   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [11:0] VPL_OFS_CTRL = 12'h000;
   localparam logic [11:0] VPL_OFS_STAT = 12'h004;
   localparam logic [11:0] VPL_OFS_MOD = 12'h008;

   // ---------------------------------------------------------------
   // field layout
   // ---------------------------------------------------------------
   localparam int VPL_CTRL_WSEL_LSB = 0;
   localparam int VPL_CTRL_RUN_BIT = 4;
   localparam int VPL_STAT_LOCK_BIT = 0;
   localparam int VPL_STAT_EN_LSB = 1;
   localparam int VPL_STAT_AUX_BIT = 4;
   localparam int VPL_STAT_SEL_LSB = 8;
   localparam int VPL_MOD_L_LSB = 0;
   localparam int VPL_MOD_S_LSB = 8;

   // ---------------------------------------------------------------
   // reset values and widths
   // ---------------------------------------------------------------
   localparam logic [3:0] VPL_WSEL_RST = 4'h1;
   localparam logic VPL_RUN_RST = 1'b0;
   localparam int VPL_STAGES = 3;
   localparam logic [6:0] VPL_L_STEP = 7'h04;
   localparam logic [3:0] VPL_S_ONE = 4'h1;

endpackage : vpl_pkg

//--- tb/vpl_board_model.sv
// board model: reference sources, display enable and enable-chain wiring
// assumes the core samples every input on pclk
module vpl_board_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic disp_en,
   input wire logic vdram_mode,
   input wire logic add_ff,
   input wire logic out_first,
   input wire logic out_second,
   input wire logic word_strobe,
   output logic ref_2x,
   output logic ref_1x,
   output logic en_first,
   output logic en_third
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] ph_r;
   logic ff_r;
   logic sec_d;
   logic ws_d;
   // 2x period is four pclks; 1x moves on 2x falling edges
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ph_r <= 3'h0;
      else
         ph_r <= ph_r + 3'h1;
   end
   assign ref_2x = ph_r[1];
   assign ref_1x = ph_r[2];
   assign en_first = disp_en;
   // optional extra flip-flop between second output and third input;
   // it takes the value that stood just before each word strobe rise
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ff_r <= 1'b0;
         sec_d <= 1'b0;
         ws_d <= 1'b0;
      end
      else
      begin
         sec_d <= out_second;
         ws_d <= word_strobe;
         if (word_strobe && !ws_d)
            ff_r <= sec_d;
      end
   end
   // vdram wiring takes the first output, fifo wiring the second
   assign en_third = vdram_mode ? out_first
                   : (add_ff ? ff_r : out_second);
endmodule : vpl_board_model

//--- tb/tb_video_pixel_load_clock_divider.sv
// self-checking bench for the pixel/load clock divider core
// assumes the board model supplies references and chain wiring
module tb_video_pixel_load_clock_divider
   import vpl_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic ref_div_sel_bit0, ref_div_sel_bit1, ref_div_sel_bit2;
   logic reference_1x_input, reference_2x_clock, horizontal_feedback_input;
   logic ext_horizontal_ref, load_timing_adjust, e;
   logic chain_enable_in_first, chain_enable_in_third;
   logic chain_enable_out_first, chain_enable_out_second;
   logic chain_enable_out_third, chain_enable_out_third_n;
   logic word_strobe_ttl_a, memory_shift_strobe, fifo_write_strobe;
   logic shifter_load_strobe, shifter_load_strobe_n, ref_divider_output;
   logic processor_phase_one, processor_phase_two;
   logic pump_up, pump_down, aux_pump_up, aux_pump_down;
   logic disp_en, vdram_mode, add_ff;
   int bad_count = 0, checked = 0, cyc = 0, up_cnt, dn_cnt;
   int last_r [6], prev_r [6], first_r [6], wid [6], g [9];
   logic [5:0] mon, mon_d = 6'h0;

   vpl_clock_divider uut (.*);
   vpl_board_model board (.pclk(pclk), .presetn(presetn),
      .disp_en(disp_en), .vdram_mode(vdram_mode), .add_ff(add_ff),
      .out_first(chain_enable_out_first), .out_second(chain_enable_out_second),
      .word_strobe(word_strobe_ttl_a), .ref_2x(reference_2x_clock),
      .ref_1x(reference_1x_input), .en_first(chain_enable_in_first),
      .en_third(chain_enable_in_third));

   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   // -----------------------------------------------------------------
   // edge monitor and tasks
   // -----------------------------------------------------------------
   assign mon = {processor_phase_one, ref_divider_output, shifter_load_strobe,
                 fifo_write_strobe, memory_shift_strobe, word_strobe_ttl_a};
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      mon_d <= mon;
      for (int i = 0; i < 6; i++)
      begin
         if (mon[i] && !mon_d[i])
         begin
            prev_r[i] <= last_r[i];
            last_r[i] <= cyc;
            if (first_r[i] < 0)
               first_r[i] <= cyc;
         end
         if (!mon[i] && mon_d[i])
            wid[i] <= cyc - last_r[i];
      end
      if (aux_pump_up)
         up_cnt++;
      if (aux_pump_down)
         dn_cnt++;
   end
   always @(negedge pclk)
   begin
      if (presetn)
      begin
         check({31'h0, processor_phase_one & processor_phase_two}, 0);
         check({31'h0, shifter_load_strobe_n},
               {31'h0, ~shifter_load_strobe});
         check({31'h0, chain_enable_out_third_n},
               {31'h0, ~chain_enable_out_third});
         check({31'h0, pump_up & pump_down}, 0);
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      paddr <= a;
      pwrite <= wr;
      pwdata <= d;
      psel <= 1'b1;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50)
      begin
         n++;
         @(posedge pclk);
      end
      if (n == 50)
         bad_count++;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle cycle so a following call never re-raises psel in this step
      @(posedge pclk);
   endtask : apb

   task automatic order_run(input logic vd, input logic ff, input int k);
      disp_en <= 1'b0;
      vdram_mode <= vd;
      add_ff <= ff;
      repeat (64) @(posedge pclk);
      first_r = '{default: -1};
      disp_en <= 1'b1;
      repeat (96) @(posedge pclk);
      g[k] = first_r[2] - first_r[1];
      g[k + 1] = first_r[3] - first_r[2];
      g[k + 2] = first_r[3] - first_r[1];
      check(32'(g[k + 2] % 8), 0);
      check({31'h0, g[k] > 0 && g[k + 2] > 0}, 1);
   endtask : order_run

   task automatic aux_try(input logic ext_first, input int d, input int k);
      up_cnt = 0;
      dn_cnt = 0;
      if (ext_first)
         ext_horizontal_ref <= 1'b1;
      else
         horizontal_feedback_input <= 1'b1;
      repeat (d) @(posedge pclk);
      ext_horizontal_ref <= 1'b1;
      horizontal_feedback_input <= 1'b1;
      repeat (4) @(posedge pclk);
      ext_horizontal_ref <= 1'b0;
      horizontal_feedback_input <= 1'b0;
      repeat (12) @(posedge pclk);
      g[k] = up_cnt;
      g[k + 1] = dn_cnt;
   endtask : aux_try

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : tally_and_finish

   initial
   begin
      repeat (30000) @(posedge pclk);
      bad_count++;
      tally_and_finish();
   end

   // -----------------------------------------------------------------
   // test sequence
   // -----------------------------------------------------------------
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {ref_div_sel_bit2, ref_div_sel_bit1, ref_div_sel_bit0} = 3'h0;
      {horizontal_feedback_input, ext_horizontal_ref} = 2'h0;
      {load_timing_adjust, disp_en, vdram_mode, add_ff} = 4'h0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, VPL_OFS_CTRL, 0);
      check(q, 32'h1);
      apb(1'b1, VPL_OFS_MOD, 0);
      apb(1'b0, VPL_OFS_MOD, 0);
      check({20'h0, q[11:0]}, 32'h108);
      apb(1'b1, 12'h00c, 32'hffffffff);
      apb(1'b0, 12'h00c, 0);
      check({e, q[30:0]}, 32'h80000000);
      $display("test registers done");
      disp_en <= 1'b1;
      for (int w = 0; w < 16; w++)
      begin
         apb(1'b1, VPL_OFS_CTRL, 32'h10 | w);
         apb(1'b0, VPL_OFS_MOD, 0);
         check({25'h0, q[6:0]}, 32'((w + 1) * 4));
         repeat (24 * (w + 1) + 8) @(posedge pclk);
         check(last_r[3] - prev_r[3], (w + 1) * 4);
         check(wid[0], (w + 1) * 2);
         check(last_r[2] - last_r[0], 0);
      end
      $display("test word width done");
      for (int v = 0; v < 8; v++)
      begin
         {ref_div_sel_bit2, ref_div_sel_bit1, ref_div_sel_bit0} <= 3'(v);
         repeat (24 * (v + 1) + 16) @(posedge pclk);
         check(last_r[4] - prev_r[4], 8 * (v + 1));
         check(last_r[5] - prev_r[5], 8);
         apb(1'b0, VPL_OFS_MOD, 0);
         check({28'h0, q[11:8]}, v + 1);
         apb(1'b0, VPL_OFS_STAT, 0);
         check({29'h0, q[10:8]}, v);
      end
      $display("test reference divider done");
      apb(1'b1, VPL_OFS_CTRL, 32'h11);
      order_run(1'b0, 1'b0, 0);
      order_run(1'b0, 1'b1, 3);
      order_run(1'b1, 1'b0, 6);
      check({31'h0, g[1] > 0 && g[1] % 8 == 0}, 1);
      check({31'h0, g[4] > g[1]}, 1);
      check({31'h0, g[8] < g[2]}, 1);
      $display("test load order done");
      repeat (40) @(posedge pclk);
      check(last_r[3] - last_r[0], 0);
      load_timing_adjust <= 1'b1;
      repeat (40) @(posedge pclk);
      check(last_r[3] - last_r[0], 1);
      $display("test timing adjust done");
      aux_try(1'b1, 3, 0);
      aux_try(1'b1, 6, 2);
      aux_try(1'b0, 6, 4);
      check(g[2] + g[3] - g[0] - g[1], 3);
      check(g[2] * g[3] + g[0] * g[1], 0);
      check({31'h0, (g[2] > 0) != (g[4] > 0)}, 1);
      $display("test aux comparator done");
      tally_and_finish();
   end
endmodule : tb_video_pixel_load_clock_divider
